/* File: rtl/ari_seq.v */
// reset, fuse load and calibration sequencer for the converter register file
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "ari_defines.vh"
module ari_seq #(
  parameter CAL_CYCLES = `ARI_CAL_CYCLES,
  parameter NWORDS = `ARI_NWORDS
) (
  input wire clk_i,
  input wire rst_i,
  input wire hw_reset_i,
  input wire wr_en_i,
  input wire [`ARI_ADDR_W-1:0] wr_addr_i,
  input wire [`ARI_DATA_W-1:0] wr_data_i,
  input wire [`ARI_ADDR_W-1:0] rd_addr_i,
  input wire [`ARI_DATA_W-1:0] fuse_data_i,
  output reg [`ARI_ADDR_W-1:0] fuse_addr_o,
  output reg [`ARI_DATA_W-1:0] rd_data_o,
  output reg busy_o,
  output reg cal_active_o,
  output reg ready_o
);
  // ----------------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------------
  localparam ST_RESET = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_CAL = 2'h2;
  localparam ST_RUN = 2'h3;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`ARI_CNT_W-1:0] cnt_q;
  reg [`ARI_CNT_W-1:0] cnt_d;
  reg [`ARI_ADDR_W-1:0] idx_q;
  reg [`ARI_ADDR_W-1:0] idx_d;
  reg [`ARI_DATA_W-1:0] regs_q [0:NWORDS-1];
  reg hw_s1_q;
  reg hw_s2_q;
  wire sw_req;
  wire ctrl_wr;
  wire data_wr;
  wire [31:0] cal_span;
  wire [`ARI_CNT_W-1:0] cal_last;
  reg [`ARI_DATA_W-1:0] rd_d;
  reg busy_d;
  reg cal_d;
  reg ready_d;
  // ----------------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------------
  // control word sits alone at the bottom of the map
  function is_ctrl_addr;
    input [`ARI_ADDR_W-1:0] a;
    begin
      is_ctrl_addr = (a == `ARI_REG_SW_RESET);
    end
  endfunction
  // span is a parameter; cut to the counter width on purpose
  assign cal_span = CAL_CYCLES - 1;
  assign cal_last = cal_span[`ARI_CNT_W-1:0];
  // reset pin is asynchronous to the clock, two stages before use
  always @(posedge clk_i)
  begin
    hw_s1_q <= hw_reset_i;
    hw_s2_q <= hw_s1_q;
  end
  // writes ignored while the sequence is busy; only run state accepts them
  assign ctrl_wr = wr_en_i && (state_q == ST_RUN) && is_ctrl_addr(wr_addr_i);
  assign data_wr = wr_en_i && (state_q == ST_RUN) && !is_ctrl_addr(wr_addr_i);
  assign sw_req = ctrl_wr && wr_data_i[`ARI_BIT_SW_RESET];
  // ----------------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------------
  always @*
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    case (state_q)
      ST_RESET:
      begin
        idx_d = {`ARI_ADDR_W{1'b0}};
        if (!hw_s2_q)
          state_d = ST_LOAD;
      end
      ST_LOAD:
      begin
        idx_d = idx_q + 1'b1;
        if (idx_q == `ARI_FUSE_WORDS)
        begin
          state_d = ST_CAL;
          cnt_d = {`ARI_CNT_W{1'b0}};
        end
      end
      ST_CAL:
      begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == cal_last)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (sw_req)
        begin
          state_d = ST_LOAD;
          idx_d = {`ARI_ADDR_W{1'b0}};
        end
      end
      default:
        state_d = ST_RESET;
    endcase
    if (hw_s2_q)
      state_d = ST_RESET;
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_RESET;
      cnt_q <= {`ARI_CNT_W{1'b0}};
      idx_q <= {`ARI_ADDR_W{1'b0}};
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
    end
  end
  // ----------------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------------
  // fuse word for index n arrives one cycle after fuse_addr_o shows n
  always @(posedge clk_i)
  begin
    if (state_q == ST_LOAD && idx_q != {`ARI_ADDR_W{1'b0}})
      regs_q[idx_q - 1'b1] <= fuse_data_i;
    else if (state_q == ST_CAL && cnt_q == {`ARI_CNT_W{1'b0}})
      regs_q[`ARI_FUSE_WORDS] <= fuse_data_i;
    else if (data_wr)
      regs_q[wr_addr_i] <= wr_data_i;
  end
  // ----------------------------------------------------------------------------
  // output next values
  // ----------------------------------------------------------------------------
  always @*
  begin
    rd_d = regs_q[rd_addr_i];
    // reset bit reads high until the sequence ends, then low by itself
    if (is_ctrl_addr(rd_addr_i))
      rd_d = {{(`ARI_DATA_W-1){1'b0}}, (state_q != ST_RUN)};
    busy_d = (state_d != ST_RUN);
    cal_d = (state_d == ST_CAL);
    ready_d = (state_d == ST_RUN);
  end
  // ----------------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------------
  // fuse index leads the load by one cycle to hide the fuse latency
  always @(posedge clk_i)
  begin
    if (rst_i)
      fuse_addr_o <= {`ARI_ADDR_W{1'b0}};
    else
      fuse_addr_o <= idx_d;
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
      rd_data_o <= `ARI_ZERO8;
    else
      rd_data_o <= rd_d;
  end
  // busy is registered from the next state like ready_o, its complement, so neither can glitch
  always @(posedge clk_i)
  begin
    if (rst_i)
      busy_o <= 1'b1;
    else
      busy_o <= busy_d;
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
      cal_active_o <= 1'b0;
    else
      cal_active_o <= cal_d;
  end
  always @(posedge clk_i)
  begin
    if (rst_i)
      ready_o <= 1'b0;
    else
      ready_o <= ready_d;
  end
endmodule // ari_seq
`default_nettype wire

/* File: common/ari_defines.vh */
// constants for the reset and initialisation sequencer
`ifndef ARI_DEFINES_VH
`define ARI_DEFINES_VH
`define ARI_ADDR_W 7
`define ARI_DATA_W 8
`define ARI_REG_SW_RESET 7'h00
`define ARI_BIT_SW_RESET 0
`define ARI_CAL_CYCLES 200000
`define ARI_CNT_W 18
`define ARI_FUSE_WORDS 7'h7F
`define ARI_NWORDS 128
`define ARI_ZERO8 8'h00
`endif

/* File: bench/ari_fuse_model.sv */
// fuse model
`timescale 1ns/100ps
`default_nettype none
module ari_fuse_model (
  input wire logic clk_i,
  input wire logic [6:0] addr_i,
  output var logic [7:0] data_o
);
  always @(posedge clk_i) data_o <= {1'b0, addr_i} ^ 8'hA5;
endmodule // ari_fuse_model
`default_nettype wire

/* File: bench/ari_seq_properties.sv */
// assertions
`timescale 1ns/100ps
`default_nettype none
module ari_seq_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hw_reset_i,
  input wire logic wr_en_i,
  input wire logic cal_active_o,
  input wire logic busy_o,
  input wire logic ready_o,
  input wire logic [6:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic [7:0] rd_data_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence pin_held_s;
    hw_reset_i [*3];
  endsequence
  sequence pin_quiet_s;
    !$past(hw_reset_i, 1) && !$past(hw_reset_i, 2) && !$past(hw_reset_i, 3);
  endsequence
  soft_go_a: assert property (ready_o && wr_en_i && wr_addr_i == 7'h00 && wr_data_i[0]
    |=> busy_o) else $error("soft reset did not start");
  cal_end_a: assert property ($fell(cal_active_o) ##0 pin_quiet_s |-> ready_o)
    else $error("calibration end without ready");
  pin_rst_a: assert property (pin_held_s |=> busy_o && !cal_active_o)
    else $error("pin reset ignored");
  load_first_a: assert property ($rose(cal_active_o) |-> $past(busy_o, 100))
    else $error("calibration without load");
  self_clear_a: assert property (rd_addr_i == 7'h00 |=> rd_data_o == {7'h00, $past(busy_o)})
    else $error("reset bit readback wrong");
endmodule // ari_seq_properties
bind ari_seq ari_seq_properties u_p (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .hw_reset_i(hw_reset_i),
  .wr_en_i(wr_en_i),
  .cal_active_o(cal_active_o),
  .busy_o(busy_o),
  .ready_o(ready_o),
  .wr_addr_i(wr_addr_i),
  .wr_data_i(wr_data_i),
  .rd_addr_i(rd_addr_i),
  .rd_data_o(rd_data_o)
);
`default_nettype wire

/* File: bench/ari_seq_tb_top.sv */
// bench
`timescale 1ns/100ps
`default_nettype none
module ari_seq_tb_top;
  logic clk_i = 0, rst_i = 1, hw_reset_i = 0, wr_en_i = 0, busy_o, cal_active_o, ready_o;
  logic [6:0] wr_addr_i = 0, rd_addr_i = 0, fuse_addr_o;
  logic [7:0] wr_data_i = 0, fuse_data_i, rd_data_o;
  int n_fail = 0, check_count = 0, n;
  always #50 clk_i = ~clk_i;
  ari_fuse_model fm (.clk_i(clk_i), .addr_i(fuse_addr_o), .data_o(fuse_data_i));
  ari_seq #(.CAL_CYCLES(20)) dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .hw_reset_i(hw_reset_i),
    .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .rd_addr_i(rd_addr_i),
    .fuse_data_i(fuse_data_i),
    .fuse_addr_o(fuse_addr_o),
    .rd_data_o(rd_data_o),
    .busy_o(busy_o),
    .cal_active_o(cal_active_o),
    .ready_o(ready_o)
  );
  task chk(input logic [7:0] g, e);
    check_count++;
    if (g !== e) begin n_fail++; $display("[ERR] %0t value mismatch", $time); end
  endtask
  task t; @(posedge clk_i); #1; endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    t; {wr_en_i, wr_addr_i, wr_data_i} = {1'b1, a, d}; t; wr_en_i = 0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    t; rd_addr_i = a; t; chk(rd_data_o, e);
  endtask
  task wt;
    for (n = 0; !ready_o && n < 170; n++) t;
    chk({7'h0, n > 144 && n < 170}, 8'h01);
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin #200000; n_fail++; end_of_test; end
  initial begin
    repeat (8) t;
    rst_i = 0;
    wt;
    wr(7'h05, 8'h3C);
    wr(7'h00, 8'h01);
    wt;
    rd(7'h05, 8'hA0);
    rd(7'h00, 8'h00);
    wr(7'h05, 8'h3C);
    hw_reset_i = 1;
    repeat (10) t;
    hw_reset_i = 0;
    wt;
    rd(7'h05, 8'hA0);
    end_of_test;
  end
endmodule // ari_seq_tb_top
`default_nettype wire
